// ### efs_event_irq.sv
// Purpose: Framer event status, receive alarm status, two interrupt masks and one interrupt line
// Assumes: Event inputs are one-cycle pulses synchronous to mclk
// Notes: Status registers clear on read; an event in the clearing cycle survives
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "efs_regs.svh"
module efs_event_irq #(
  parameter int SECOND_CYCLES   = `EFS_SECOND_NS / `EFS_MCLK_NS,
  parameter int SHORT_CYCLES    = `EFS_SHORT_INTERVAL_NS / `EFS_MCLK_NS,
  parameter int CRC_FREE_CYCLES = `EFS_CRC_FREE_NS / `EFS_MCLK_NS
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Framer timing events
  input  wire logic         rxMfPulse,
  input  wire logic         rxAlignPulse,
  input  wire logic         txMfPulse,
  input  wire logic         txAlignPulse,
  input  wire logic         rxCrcMfPulse,
  input  wire logic         txClockLostPulse,
  input  wire logic         txSlipPulse,
  // Receive alarm events, same layout as the alarm mask
  input  wire logic [7:0]   rxAlarmPulse,
  // Interrupt
  output logic              irq
);
  logic                rstSync1_reg;
  logic                rstN;
  logic                rdPend_reg;
  logic                wrPend_reg;
  logic [7:0]          wrIdx_reg;
  logic [7:0]          addrIdx;
  logic                accept;
  logic                rdAccept;
  logic                wrData;
  efs_pkg::efs_byte_t  timingStatus_reg;
  efs_pkg::efs_byte_t  timingStatus_next;
  efs_pkg::efs_byte_t  alarmStatus_reg;
  efs_pkg::efs_byte_t  alarmStatus_next;
  efs_pkg::efs_byte_t  alarmMask_reg;
  efs_pkg::efs_byte_t  timingMask_reg;
  efs_pkg::efs_byte_t  control_reg;
  efs_pkg::efs_byte_t  timingSet;
  efs_pkg::efs_byte_t  timingClr;
  efs_pkg::efs_byte_t  alarmClr;
  efs_pkg::efs_byte_t  rdMux;
  logic                crc4Enable;
  logic                crcEvent;
  logic                irq_reg;

  efs_tick_if secIf ();
  efs_tick_if crcIf ();

  // Reset release through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_reg <= 1'b0;
      rstN         <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstN         <= rstSync1_reg;
    end
  end

  // R07 interval timer select
  assign secIf.run = 1'b1;
  assign secIf.sel = control_reg[`EFS_BIT_INTERVAL_SEL];

  efs_interval_timer #(
    .PERIOD_LONG  (SECOND_CYCLES),
    .PERIOD_SHORT (SHORT_CYCLES)
  ) u_secTimer (
    .clk  (mclk),
    .rstN (rstN),
    .tk   (secIf.timer)
  );

  // R09 free boundary only without CRC4
  assign crc4Enable = control_reg[`EFS_BIT_CRC4_ENABLE];
  assign crcIf.run  = ~crc4Enable;
  assign crcIf.sel  = 1'b0;

  efs_interval_timer #(
    .PERIOD_LONG  (CRC_FREE_CYCLES),
    .PERIOD_SHORT (CRC_FREE_CYCLES)
  ) u_crcTimer (
    .clk  (mclk),
    .rstN (rstN),
    .tk   (crcIf.timer)
  );

  // R08 R09 CRC4 boundary source
  assign crcEvent = crc4Enable ? rxCrcMfPulse : crcIf.tick;

  // Bus decode; zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrIdx   = haddr[9:2];
  assign accept    = hsel & htrans[1] & hready;
  assign rdAccept  = accept & ~hwrite;
  assign wrData    = wrPend_reg & hready;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rdPend_reg <= 1'b0;
      wrPend_reg <= 1'b0;
      wrIdx_reg  <= 8'h00;
    end else if (hready) begin
      rdPend_reg <= rdAccept;
      wrPend_reg <= accept & hwrite;
      wrIdx_reg  <= addrIdx;
    end
  end

  // Read data captured at the address phase so the data phase has it at once
  always_comb begin
    rdMux = 8'h00;
    case (addrIdx)
      `EFS_IDX_ALARM_STATUS:  rdMux = alarmStatus_reg;
      `EFS_IDX_TIMING_STATUS: rdMux = timingStatus_reg;
      `EFS_IDX_ALARM_MASK:    rdMux = alarmMask_reg;
      `EFS_IDX_TIMING_MASK:   rdMux = timingMask_reg;
      `EFS_IDX_CONTROL:       rdMux = control_reg;
      default:                rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      hrdata <= 32'h0;
    end else if (rdAccept) begin
      hrdata <= {24'h0, rdMux};
    end
  end

  // Mask and control writes in the data phase
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      alarmMask_reg  <= `EFS_RST_MASK;
      timingMask_reg <= `EFS_RST_MASK;
      control_reg    <= `EFS_RST_CONTROL;
    end else if (wrData) begin
      case (wrIdx_reg)
        `EFS_IDX_ALARM_MASK:  alarmMask_reg  <= hwdata[7:0];
        `EFS_IDX_TIMING_MASK: timingMask_reg <= hwdata[7:0];
        `EFS_IDX_CONTROL:     control_reg    <= hwdata[7:0];
        default:              control_reg    <= control_reg;
      endcase
    end
  end

  // Event sources of the timing status bits
  always_comb begin
    timingSet = 8'h00;
    // R01 R02 receive signaling ready
    timingSet[`EFS_BIT_RX_MF] = rxMfPulse;
    // R03 R04 spare bits captured
    timingSet[`EFS_BIT_RX_ALIGN] = rxAlignPulse;
    // R05 R06 transmit signaling refresh
    timingSet[`EFS_BIT_TX_MF] = txMfPulse;
    // R07 interval timer tick
    timingSet[`EFS_BIT_TIMER] = secIf.tick;
    // R13 transmit align frame
    timingSet[`EFS_BIT_TX_ALIGN] = txAlignPulse;
    timingSet[`EFS_BIT_TX_CLK_LOST] = txClockLostPulse;
    // R08 R09 CRC4 multiframe
    timingSet[`EFS_BIT_RX_CRC_MF] = crcEvent;
    timingSet[`EFS_BIT_TX_SLIP] = txSlipPulse;
  end

  // Clear on read, set wins over clear
  assign timingClr         = (rdAccept && addrIdx == `EFS_IDX_TIMING_STATUS) ? 8'hff : 8'h00;
  assign alarmClr          = (rdAccept && addrIdx == `EFS_IDX_ALARM_STATUS) ? 8'hff : 8'h00;
  assign timingStatus_next = (timingStatus_reg & ~timingClr) | timingSet;
  assign alarmStatus_next  = (alarmStatus_reg & ~alarmClr) | rxAlarmPulse;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      timingStatus_reg <= `EFS_RST_STATUS;
      alarmStatus_reg  <= `EFS_RST_STATUS;
    end else begin
      timingStatus_reg <= timingStatus_next;
      alarmStatus_reg  <= alarmStatus_next;
    end
  end

  // R10 R11 R12 masked interrupt level
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(alarmStatus_next & alarmMask_reg) | |(timingStatus_next & timingMask_reg);
    end
  end

  assign irq = irq_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  property p_rx_mf_set;
    rxMfPulse |=> timingStatus_reg[`EFS_BIT_RX_MF];
  endproperty
  a_rx_mf_set: assert property (p_rx_mf_set) else $error("rx multiframe flag not set"); // R01

  property p_rx_align_set;
    rxAlignPulse |=> timingStatus_reg[`EFS_BIT_RX_ALIGN];
  endproperty
  a_rx_align_set: assert property (p_rx_align_set) else $error("rx align flag not set"); // R03

  property p_tx_mf_set;
    txMfPulse |=> timingStatus_reg[`EFS_BIT_TX_MF];
  endproperty
  a_tx_mf_set: assert property (p_tx_mf_set) else $error("tx multiframe flag not set"); // R05

  property p_tx_align_set;
    txAlignPulse |=> timingStatus_reg[`EFS_BIT_TX_ALIGN];
  endproperty
  a_tx_align_set: assert property (p_tx_align_set) else $error("tx align flag not set"); // R13

  property p_timer_set;
    secIf.tick |=> timingStatus_reg[`EFS_BIT_TIMER];
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer flag not set"); // R07

  property p_crc_enabled;
    crc4Enable && rxCrcMfPulse |=> timingStatus_reg[`EFS_BIT_RX_CRC_MF];
  endproperty
  a_crc_enabled: assert property (p_crc_enabled) else $error("crc multiframe flag not set"); // R08

  property p_crc_free;
    !crc4Enable && crcIf.tick |=> timingStatus_reg[`EFS_BIT_RX_CRC_MF];
  endproperty
  a_crc_free: assert property (p_crc_free) else $error("free crc boundary lost"); // R09

  property p_alarm_irq;
    |(rxAlarmPulse & alarmMask_reg) |=> irq;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("enabled alarm gave no interrupt"); // R10

  property p_timing_irq;
    |(timingSet & timingMask_reg) |=> irq;
  endproperty
  a_timing_irq: assert property (p_timing_irq) else $error("enabled timing event gave no interrupt"); // R11

  // Irq lags a mask write by one cycle, so only compare while masks are steady
  property p_irq_masked;
    $stable(alarmMask_reg) && $stable(timingMask_reg) |->
      irq == (|(alarmStatus_reg & alarmMask_reg) || |(timingStatus_reg & timingMask_reg));
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt disagrees with masked status"); // R12

  property p_read_clears;
    rdAccept && addrIdx == `EFS_IDX_TIMING_STATUS && timingSet == 8'h00 |=> timingStatus_reg == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear"); // R02

  // Bus and register checks
  property p_read_upper;
    rdPend_reg |-> hrdata[31:8] == 24'h000000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("read data upper bits not zero"); // R02

  property p_read_hold;
    !rdAccept |=> $stable(hrdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data changed without a read"); // R02

  property p_alarm_mask_write;
    wrData && wrIdx_reg == `EFS_IDX_ALARM_MASK |=> alarmMask_reg == $past(hwdata[7:0]);
  endproperty
  a_alarm_mask_write: assert property (p_alarm_mask_write) else $error("alarm mask write lost"); // R10

  property p_timing_mask_write;
    wrData && wrIdx_reg == `EFS_IDX_TIMING_MASK |=> timingMask_reg == $past(hwdata[7:0]);
  endproperty
  a_timing_mask_write: assert property (p_timing_mask_write) else $error("timing mask write lost"); // R11

  property p_control_write;
    wrData && wrIdx_reg == `EFS_IDX_CONTROL |=> control_reg == $past(hwdata[7:0]);
  endproperty
  a_control_write: assert property (p_control_write) else $error("control write lost"); // R07

  // Status, interrupt and timer tick checks
  property p_alarm_set;
    rxAlarmPulse != 8'h00 |=> (alarmStatus_reg & $past(rxAlarmPulse)) == $past(rxAlarmPulse);
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set"); // R10

  property p_alarm_clears;
    rdAccept && addrIdx == `EFS_IDX_ALARM_STATUS && rxAlarmPulse == 8'h00 |=> alarmStatus_reg == 8'h00;
  endproperty
  a_alarm_clears: assert property (p_alarm_clears) else $error("alarm status read did not clear"); // R10

  property p_timing_sticky;
    !(rdAccept && addrIdx == `EFS_IDX_TIMING_STATUS) |=>
      (timingStatus_reg & $past(timingStatus_reg)) == $past(timingStatus_reg);
  endproperty
  a_timing_sticky: assert property (p_timing_sticky) else $error("timing flag lost before read"); // R02

  property p_alarm_sticky;
    !(rdAccept && addrIdx == `EFS_IDX_ALARM_STATUS) |=>
      (alarmStatus_reg & $past(alarmStatus_reg)) == $past(alarmStatus_reg);
  endproperty
  a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm flag lost before read"); // R10

  property p_masks_off;
    alarmMask_reg == 8'h00 && timingMask_reg == 8'h00 |=> !irq;
  endproperty
  a_masks_off: assert property (p_masks_off) else $error("interrupt with all masks clear"); // R12

  property p_crc_held;
    $past(crc4Enable) |-> !crcIf.tick;
  endproperty
  a_crc_held: assert property (p_crc_held) else $error("free crc boundary while crc4 enabled"); // R08

  property p_timer_gap;
    secIf.tick |=> !secIf.tick;
  endproperty
  a_timer_gap: assert property (p_timer_gap) else $error("timer ticked twice in a row"); // R07

  property p_tx_clk_lost_set;
    txClockLostPulse |=> timingStatus_reg[`EFS_BIT_TX_CLK_LOST];
  endproperty
  a_tx_clk_lost_set: assert property (p_tx_clk_lost_set) else $error("tx clock lost flag not set"); // R11

  property p_tx_slip_set;
    txSlipPulse |=> timingStatus_reg[`EFS_BIT_TX_SLIP];
  endproperty
  a_tx_slip_set: assert property (p_tx_slip_set) else $error("tx slip flag not set"); // R11

  c_timer_tick:  cover property (secIf.tick);
  c_irq_rise:    cover property ($rose(irq));
  c_status_read: cover property (rdAccept && addrIdx == `EFS_IDX_TIMING_STATUS && timingStatus_reg != 8'h00);
  c_set_on_clr:  cover property (rdAccept && addrIdx == `EFS_IDX_TIMING_STATUS && timingSet != 8'h00);
  c_crc_free:    cover property (crcIf.tick);
endmodule

// ### efs_regs.svh
// Purpose: Register map, field positions, reset values and timing figures of the framer event block
// Assumes: 32-bit AHB-Lite data, one register per aligned word, byte address is four times the index
// Notes: Status registers clear on read, masks and control are read-write
// Contract
// R01 - Receive multiframe sets status bit seven
// R02 - That bit means receive signaling readable
// R03 - Receive align frame start sets bit six
// R04 - That bit means new spare bits captured
// R05 - Transmit multiframe boundary sets bit five
// R06 - That bit means transmit signaling needs refresh
// R07 - Timer bit four: second or 62.5ms
// R08 - Receive CRC4 multiframe sets bit one
// R09 - CRC4 off: free 2ms boundary instead
// R10 - First mask gates eight receive alarms
// R11 - Second mask gates timing status bits
// R12 - Interrupt while any enabled flag set
// R13 - Transmit align frame start sets bit three
`ifndef EFS_REGS_SVH
`define EFS_REGS_SVH

// Register indices (byte address = index * 4)
`define EFS_IDX_ALARM_STATUS   8'h06
`define EFS_IDX_TIMING_STATUS  8'h07
`define EFS_IDX_ALARM_MASK     8'h16
`define EFS_IDX_TIMING_MASK    8'h17
`define EFS_IDX_CONTROL        8'h1a

// Reset values
`define EFS_RST_STATUS         8'h00
`define EFS_RST_MASK           8'h00
`define EFS_RST_CONTROL        8'h00

// Timing status bit positions
`define EFS_BIT_RX_MF          7
`define EFS_BIT_RX_ALIGN       6
`define EFS_BIT_TX_MF          5
`define EFS_BIT_TIMER          4
`define EFS_BIT_TX_ALIGN       3
`define EFS_BIT_TX_CLK_LOST    2
`define EFS_BIT_RX_CRC_MF      1
`define EFS_BIT_TX_SLIP        0

// Control register bit positions
`define EFS_BIT_INTERVAL_SEL   7
`define EFS_BIT_CRC4_ENABLE    0

// Timing figures
`define EFS_MCLK_NS            10
`define EFS_SECOND_NS          1000000000
`define EFS_SHORT_INTERVAL_NS  62500000
`define EFS_CRC_FREE_NS        2000000

`endif

// ### efs_pkg.sv
// Purpose: Shared types of the framer event block
// Assumes: Nothing beyond the register header
// Notes: Register contents are one byte wide
package efs_pkg;
  typedef logic [7:0] efs_byte_t;
  typedef logic [26:0] efs_count_t;
endpackage

// ### efs_tick_if.sv
// Purpose: Carries run, select and tick between the top and an interval timer
// Assumes: One clock domain
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ns
interface efs_tick_if;
  logic run;
  logic sel;
  logic tick;
  modport timer (input run, input sel, output tick);
  modport user  (output run, output sel, input tick);
endinterface

// ### efs_interval_timer.sv
// Purpose: Free-running interval divider giving a one-cycle tick at one of two periods
// Assumes: Periods of at least two cycles, below 2**27
// Notes: Counter restarts while run is low
`timescale 1ns/1ns
module efs_interval_timer #(
  parameter int PERIOD_LONG  = 100000000,
  parameter int PERIOD_SHORT = 6250000
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rstN,
  // Control and tick
  efs_tick_if.timer  tk
);
  efs_pkg::efs_count_t cnt_reg;
  efs_pkg::efs_count_t lastCount;

  assign lastCount = tk.sel ? 27'(PERIOD_SHORT - 1) : 27'(PERIOD_LONG - 1);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_reg <= 27'h0;
      tk.tick <= 1'b0;
    end else if (!tk.run) begin
      cnt_reg <= 27'h0;
      tk.tick <= 1'b0;
    end else if (cnt_reg >= lastCount) begin
      // Also catches a count left above a newly shortened period
      cnt_reg <= 27'h0;
      tk.tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 27'h1;
      tk.tick <= 1'b0;
    end
  end
endmodule

// ### efs_event_irq_bench.sv
// Purpose: Self-checking bench of the framer event block over AHB-Lite
// Assumes: Zero-wait slave, short timer parameters
// Notes: Timer and free CRC ticks are left out of status compares where they may land
`timescale 1ns/1ns
`include "efs_regs.svh"
module efs_event_irq_bench;
  localparam int LONG  = 40;
  localparam int SHORT = 10;
  localparam int CRCF  = 16;
  logic        mclk;
  logic        nrst;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [7:0]  timPulse;
  logic [7:0]  alarmPulse;
  int          failCount;
  int          comparisons;
  int          cyc;

  assign hready = hreadyout;

  efs_event_irq #(.SECOND_CYCLES(LONG), .SHORT_CYCLES(SHORT), .CRC_FREE_CYCLES(CRCF)) dut (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rxMfPulse(timPulse[7]), .rxAlignPulse(timPulse[6]), .txMfPulse(timPulse[5]),
    .txAlignPulse(timPulse[3]), .txClockLostPulse(timPulse[2]), .rxCrcMfPulse(timPulse[1]),
    .txSlipPulse(timPulse[0]), .rxAlarmPulse(alarmPulse), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  task automatic finishTest();
    if (failCount == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] care);
    comparisons++;
    if ((got & care) !== (exp & care)) begin
      failCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; entered and left just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'b00};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] v;
    xfer(1'b1, idx, d, v);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] care);
    logic [31:0] v;
    xfer(1'b0, idx, 8'h00, v);
    check(v, exp, care);
  endtask

  task automatic pulse(input logic [7:0] t, input logic [7:0] a);
    timPulse   <= t;
    alarmPulse <= a;
    @(posedge mclk);
    timPulse   <= 8'h00;
    alarmPulse <= 8'h00;
    @(posedge mclk);
  endtask

  // Masked event must not raise irq, enabled one must, read clears both
  task automatic ev(input logic [7:0] sIdx, input logic [7:0] mIdx, input logic [7:0] care,
                    input logic [7:0] tp, input logic [7:0] ap, input logic [7:0] b);
    wr(mIdx, care & ~b);
    rd(sIdx, 32'h0, 32'h0);
    pulse(tp, ap);
    check({31'h0, irq}, 32'h0, 32'h1);
    rd(sIdx, {24'h0, b}, {24'h0, care});
    wr(mIdx, b);
    pulse(tp, ap);
    check({31'h0, irq}, 32'h1, 32'h1);
    rd(sIdx, {24'h0, b}, {24'h0, care});
    check({31'h0, irq}, 32'h0, 32'h1);
  endtask

  task automatic waitIrq(output int t);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    t = cyc;
  endtask

  // Distance between two ticks seen through the interrupt line
  task automatic period(input logic [7:0] ctrl, input logic [7:0] mask, input int exp);
    int t0;
    int t1;
    wr(`EFS_IDX_CONTROL, ctrl);
    wr(`EFS_IDX_TIMING_MASK, mask);
    waitIrq(t0);
    rd(`EFS_IDX_TIMING_STATUS, 32'h0, 32'h0);
    waitIrq(t0);
    rd(`EFS_IDX_TIMING_STATUS, 32'h0, 32'h0);
    waitIrq(t1);
    check(t1 - t0, exp, 32'hffffffff);
  endtask

  initial begin
    #100000;
    failCount++;
    finishTest();
  end

  initial begin
    nrst = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00; hsize = 3'b010;
    haddr = 32'h0; hwdata = 32'h0; timPulse = 8'h00; alarmPulse = 8'h00;
    failCount = 0; comparisons = 0; cyc = 0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`EFS_IDX_ALARM_MASK, 32'h0, 32'hffffffff);
    rd(`EFS_IDX_TIMING_MASK, 32'h0, 32'hffffffff);
    rd(`EFS_IDX_ALARM_STATUS, 32'h0, 32'hffffffff);
    rd(`EFS_IDX_TIMING_STATUS, 32'h0, 32'hffffffed);
    check({31'h0, hresp}, 32'h0, 32'h1);
    wr(`EFS_IDX_ALARM_MASK, 8'ha5);
    rd(`EFS_IDX_ALARM_MASK, 32'ha5, 32'hffffffff);
    wr(`EFS_IDX_TIMING_MASK, 8'h5a);
    rd(`EFS_IDX_TIMING_MASK, 32'h5a, 32'hffffffff);
    wr(`EFS_IDX_ALARM_MASK, 8'h00);
    wr(`EFS_IDX_TIMING_MASK, 8'h00);
    wr(`EFS_IDX_ALARM_STATUS, 8'hff);
    rd(`EFS_IDX_ALARM_STATUS, 32'h0, 32'hffffffff);
    wr(8'h30, 8'hff);
    rd(8'h30, 32'h0, 32'hffffffff);
    wr(`EFS_IDX_CONTROL, 8'h01);
    rd(`EFS_IDX_TIMING_STATUS, 32'h0, 32'h0);
    wr(`EFS_IDX_TIMING_STATUS, 8'hff);
    rd(`EFS_IDX_TIMING_STATUS, 32'h0, 32'hef);
    for (int i = 0; i < 8; i++) begin
      if (i != 4) ev(`EFS_IDX_TIMING_STATUS, `EFS_IDX_TIMING_MASK, 8'hef, 8'h01 << i, 8'h00, 8'h01 << i);
    end
    for (int i = 0; i < 8; i++) begin
      ev(`EFS_IDX_ALARM_STATUS, `EFS_IDX_ALARM_MASK, 8'hff, 8'h00, 8'h01 << i, 8'h01 << i);
    end
    wr(`EFS_IDX_ALARM_MASK, 8'h00);
    period(8'h01, 8'h10, LONG);
    period(8'h81, 8'h10, SHORT);
    period(8'h00, 8'h02, CRCF);
    finishTest();
  end
endmodule
